// ---- rtl/sram_port_power_fail_guard.sv ----
// host port gating and power-fail supervision for the clock chip
`timescale 1ns/10ps
module sram_port_power_fail_guard #(
  parameter int unsigned IRQ_CYC = pf_guard_pkg::IRQ_DELAY_CYC,
  parameter int unsigned WPT_CYC = pf_guard_pkg::WPT_CYC,
  parameter int unsigned CSR_CYC = pf_guard_pkg::CSR_CYC
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic cs_n,
  input  wire logic oe_n,
  input  wire logic we_n,
  input  wire logic sram_enable_in,
  input  wire logic supply_ok,
  input  wire logic supply_above_switch,
  input  wire logic power_fail_irq_enable,
  output logic      write_active,
  output logic      write_start,
  output logic      write_end,
  output logic      dq_oe,
  output logic      sram_enable_out,
  output logic      backup_supply_out,
  output logic      rst_n_out,
  output logic      rst_n_oe,
  output logic      irq_n_out,
  output logic      irq_n_oe
);
  localparam int unsigned TW = pf_guard_pkg::TIMER_W;

  logic [pf_guard_pkg::SYN_W-1:0] meta_ff;
  logic [pf_guard_pkg::SYN_W-1:0] sync_ff;
  logic                           cs_s;
  logic                           oe_s;
  logic                           we_s;
  logic                           sram_s;
  logic                           supply_s;
  logic                           above_s;

  pf_guard_pkg::pwr_state_e st_ff;
  pf_guard_pkg::pwr_state_e nxt_st;
  logic [TW-1:0]            elapsed;
  logic                     timer_clear;

  logic write_active_ff;
  logic nxt_write_active;
  logic write_start_ff;
  logic nxt_write_start;
  logic write_end_ff;
  logic nxt_write_end;
  logic dq_oe_ff;
  logic nxt_dq_oe;
  logic sram_out_ff;
  logic nxt_sram_out;
  logic battery_ff;
  logic nxt_battery;
  logic rst_oe_ff;
  logic nxt_rst_oe;
  logic irq_oe_ff;
  logic nxt_irq_oe;
  logic bus_ok;
  logic writing;

  function automatic logic reached(input logic [TW-1:0] cnt,
                                   input int unsigned   lim);
    return cnt >= TW'(lim);
  endfunction

  // pins are asynchronous to clk; first stage feeds only the second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= pf_guard_pkg::SYN_RST;
      sync_ff <= pf_guard_pkg::SYN_RST;
    end else if (clk_en) begin
      meta_ff <= {supply_above_switch, supply_ok, sram_enable_in,
                  we_n, oe_n, cs_n};
      sync_ff <= meta_ff;
    end
  end

  assign cs_s     = sync_ff[pf_guard_pkg::SYN_CS];
  assign oe_s     = sync_ff[pf_guard_pkg::SYN_OE];
  assign we_s     = sync_ff[pf_guard_pkg::SYN_WE];
  assign sram_s   = sync_ff[pf_guard_pkg::SYN_SRAM];
  assign supply_s = sync_ff[pf_guard_pkg::SYN_SUPPLY];
  assign above_s  = sync_ff[pf_guard_pkg::SYN_ABOVE];

  pf_interval_timer #(
    .WIDTH (TW)
  ) u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .clear   (timer_clear),
    .count   (elapsed)
  );

  // supply state machine; the timer restarts on every state change
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      pf_guard_pkg::ST_UP: begin
        if (!supply_s) begin
          nxt_st = pf_guard_pkg::ST_FAIL;
        end
      end
      pf_guard_pkg::ST_FAIL: begin
        if (supply_s) begin
          nxt_st = pf_guard_pkg::ST_RECOVER;
        end
      end
      pf_guard_pkg::ST_RECOVER: begin
        if (!supply_s) begin
          nxt_st = pf_guard_pkg::ST_FAIL;
        end else if (reached(elapsed, CSR_CYC)) begin
          nxt_st = pf_guard_pkg::ST_UP;
        end
      end
      default: begin
        nxt_st = pf_guard_pkg::ST_FAIL;
      end
    endcase
  end

  assign timer_clear = (nxt_st != st_ff);
  // bus only honoured in the good state
  assign bus_ok  = (st_ff == pf_guard_pkg::ST_UP);
  // write is the overlap of both lows
  assign writing = bus_ok && !cs_s && !we_s;

  always_comb begin
    nxt_write_active = writing;
    // later falling edge opens the write
    nxt_write_start  = writing && !write_active_ff;
    nxt_write_end    = !writing && write_active_ff;
    // write enable low keeps the data lines high-z
    nxt_dq_oe        = bus_ok && !cs_s && !oe_s && we_s;
    // pass sram enable while supply is good
    nxt_sram_out     = sram_s;
    nxt_rst_oe       = 1'b0;
    nxt_irq_oe       = 1'b0;
    // battery feeds backup below the switchover level
    nxt_battery      = !above_s;
    if (st_ff == pf_guard_pkg::ST_FAIL) begin
      // block and reset after the delay
      if (reached(elapsed, WPT_CYC)) begin
        nxt_sram_out = 1'b1;
        nxt_rst_oe   = 1'b1;
      end
      // interrupt after the delay, gated by enable
      nxt_irq_oe = reached(elapsed, IRQ_CYC) && power_fail_irq_enable;
    end else if (st_ff == pf_guard_pkg::ST_RECOVER) begin
      nxt_sram_out = 1'b1;
      nxt_rst_oe   = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff           <= pf_guard_pkg::ST_RECOVER;
      write_active_ff <= 1'b0;
      write_start_ff  <= 1'b0;
      write_end_ff    <= 1'b0;
      dq_oe_ff        <= 1'b0;
      sram_out_ff     <= 1'b1;
      battery_ff      <= 1'b0;
      rst_oe_ff       <= 1'b1;
      irq_oe_ff       <= 1'b0;
    end else if (clk_en) begin
      st_ff           <= nxt_st;
      write_active_ff <= nxt_write_active;
      write_start_ff  <= nxt_write_start;
      write_end_ff    <= nxt_write_end;
      dq_oe_ff        <= nxt_dq_oe;
      sram_out_ff     <= nxt_sram_out;
      battery_ff      <= nxt_battery;
      rst_oe_ff       <= nxt_rst_oe;
      irq_oe_ff       <= nxt_irq_oe;
    end
  end

  assign write_active      = write_active_ff;
  assign write_start       = write_start_ff;
  assign write_end         = write_end_ff;
  assign dq_oe             = dq_oe_ff;
  assign sram_enable_out   = sram_out_ff;
  assign backup_supply_out = battery_ff;
  // open-drain, the driven level is always low
  assign rst_n_out         = 1'b0;
  assign rst_n_oe          = rst_oe_ff;
  assign irq_n_out         = 1'b0;
  assign irq_n_oe          = irq_oe_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !clk_en);

  write_overlap_a: assert property (
    write_active_ff |-> $past(!cs_s && !we_s && bus_ok))
    else $error("write flagged without select and enable overlap");
  write_start_a: assert property (
    write_start_ff |-> write_active_ff && !$past(write_active_ff))
    else $error("write start not at opening of overlap");
  write_end_a: assert property (
    write_end_ff |-> !write_active_ff && $past(write_active_ff))
    else $error("write end not at close of overlap");
  dq_hiz_a: assert property (
    dq_oe_ff |-> $past(we_s) && !write_active_ff)
    else $error("data driven while write enable low");
  irq_delay_a: assert property (
    (st_ff == pf_guard_pkg::ST_FAIL && !reached(elapsed, IRQ_CYC)) |->
    !irq_oe_ff)
    else $error("interrupt too early after supply fail");
  irq_gate_a: assert property (
    irq_oe_ff |-> $past(power_fail_irq_enable))
    else $error("interrupt without enable");
  fail_block_a: assert property (
    (st_ff == pf_guard_pkg::ST_FAIL && nxt_st == st_ff &&
     reached(elapsed, WPT_CYC)) |=> sram_out_ff && rst_oe_ff)
    else $error("sram not blocked after protect delay");
  recover_hold_a: assert property (
    (st_ff == pf_guard_pkg::ST_RECOVER) |=> rst_oe_ff && sram_out_ff)
    else $error("reset or block released during recovery");
  recover_bus_a: assert property (
    (st_ff == pf_guard_pkg::ST_RECOVER) |=> !dq_oe_ff && !write_active_ff)
    else $error("bus honoured during protection period");
  pass_through_a: assert property (
    (bus_ok && nxt_st == st_ff) |=> sram_out_ff == $past(sram_s))
    else $error("sram enable not passed while supply good");
  battery_sel_a: assert property (
    ##1 battery_ff == $past(!above_s))
    else $error("backup source does not follow switchover");

  fail_seen_c: cover property (
    st_ff == pf_guard_pkg::ST_FAIL ##1 irq_oe_ff);
  write_seen_c: cover property (write_start_ff ##[1:20] write_end_ff);
  up_seen_c: cover property (
    st_ff == pf_guard_pkg::ST_RECOVER ##1 st_ff == pf_guard_pkg::ST_UP);
endmodule

// ---- rtl/pf_guard_pkg.sv ----
// constants and state codes for the power-fail guard
// Overview of operation
// - a write exists only while chip select and write enable are both low
// - write start is taken from the later falling edge of select or enable
// - write end is taken from the earlier rising edge of select or enable
// - data lines stay high-z when select falls with or after write enable
// - power-fail interrupt asserts 6 to 24 us after supply falls
// - after the write-protect delay, block sram enable and assert reset
// - on power-up, ignore chip select for the protection period
// - hold reset active after power-up for the protection period
// - keep sram enable blocked after power-up for the protection period
// - interrupt output only raised when the interrupt enable bit is one
// - reset and interrupt pins are open-drain, pulling low only
package pf_guard_pkg;
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  // interrupt delay window, microseconds
  localparam int unsigned IRQ_DELAY_MIN_US = 6;
  localparam int unsigned IRQ_DELAY_MAX_US = 24;
  // least time rounds up
  localparam int unsigned IRQ_DELAY_CYC =
    (IRQ_DELAY_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // sram write-protect delay after power-fail, microseconds (nominal)
  localparam int unsigned WPT_NOM_US  = 100;
  localparam int unsigned WPT_CYC     =
    (WPT_NOM_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // protection period after power-up, milliseconds (nominal)
  localparam longint unsigned CSR_NOM_MS = 200;
  localparam longint unsigned CSR_CYC_L  =
    (CSR_NOM_MS * 64'd1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CSR_CYC    = int'(CSR_CYC_L);
  localparam int unsigned TIMER_W    = 26;
  // synchronised pin vector bit positions
  localparam int unsigned SYN_CS     = 0;
  localparam int unsigned SYN_OE     = 1;
  localparam int unsigned SYN_WE     = 2;
  localparam int unsigned SYN_SRAM   = 3;
  localparam int unsigned SYN_SUPPLY = 4;
  localparam int unsigned SYN_ABOVE  = 5;
  localparam int unsigned SYN_W      = 6;
  localparam logic [SYN_W-1:0] SYN_RST = 6'h3f;
  typedef enum logic [2:0] {
    ST_UP      = 3'h1,
    ST_FAIL    = 3'h2,
    ST_RECOVER = 3'h4
  } pwr_state_e;
endpackage

// ---- rtl/pf_interval_timer.sv ----
// saturating cycle counter that measures time spent in one supply state
`timescale 1ns/10ps
module pf_interval_timer #(
  parameter int unsigned WIDTH = 26
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic             clear,
  output logic      [WIDTH-1:0] count
);
  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;

  // saturate so a long outage never wraps back into a short delay
  always_comb begin
    nxt_count = count_ff;
    if (clear) begin
      nxt_count = '0;
    end else if (count_ff != {WIDTH{1'b1}}) begin
      nxt_count = count_ff + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_ff <= '0;
    end else if (clk_en) begin
      count_ff <= nxt_count;
    end
  end

  assign count = count_ff;
endmodule

// ---- rtl/unused_placeholder_none.sv ----
// intentionally empty: no additional logic
`timescale 1ns/10ps

// ---- test/host_bus_model.sv ----
// host processor model driving the asynchronous bus strobes
`timescale 1ns/10ps
module host_bus_model (
  input  wire logic clk,
  output logic      cs_n,
  output logic      oe_n,
  output logic      we_n
);
  initial {we_n, oe_n, cs_n} = 3'h7;
  // masks are {we, oe, cs}; the host always drives, so no floating strobes
  // group one rises last
  task automatic access(input logic [2:0] lo1, input logic [2:0] lo2,
                        input int gap, input int len);
    {we_n, oe_n, cs_n} <= ~lo1;
    repeat (gap) @(posedge clk);
    {we_n, oe_n, cs_n} <= ~(lo1 | lo2);
    repeat (len) @(posedge clk);
    {we_n, oe_n, cs_n} <= ~lo1;
    repeat (3) @(posedge clk);
    {we_n, oe_n, cs_n} <= 3'h7;
    repeat (6) @(posedge clk);
  endtask
endmodule

// ---- test/sram_port_power_fail_guard_test.sv ----
// self-checking bench for the power-fail guard
`timescale 1ns/10ps
module sram_port_power_fail_guard_test;
  localparam int IRQ = 10;
  localparam int WPT = 30;
  localparam int CSR = 50;
  logic clk     = 1'b0;
  logic sys_rst = 1'b1;
  logic sram_in = 1'b1;
  logic sup_ok  = 1'b1;
  logic sup_sw  = 1'b1;
  logic irq_en  = 1'b0;
  logic cs_n, oe_n, we_n, wa, ws, wend, dq_oe, sram_out;
  logic bkp, rst_o, rst_oe, irq_o, irq_oe;
  int   bad_count = 0;
  int   tests_run = 0;
  int   cyc       = 0;
  int   wa_cyc, ws_cnt, we_cnt, dq_cnt;

  always #2.5 clk = ~clk;

  host_bus_model host (.clk(clk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n));

  sram_port_power_fail_guard #(.IRQ_CYC(IRQ), .WPT_CYC(WPT), .CSR_CYC(CSR))
  dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .sram_enable_in(sram_in), .supply_ok(sup_ok),
    .supply_above_switch(sup_sw), .power_fail_irq_enable(irq_en),
    .write_active(wa), .write_start(ws), .write_end(wend),
    .dq_oe(dq_oe), .sram_enable_out(sram_out),
    .backup_supply_out(bkp), .rst_n_out(rst_o), .rst_n_oe(rst_oe),
    .irq_n_out(irq_o), .irq_n_oe(irq_oe)
  );

  // cycle counts of the bus outputs; also cuts a hang short
  always @(posedge clk) begin
    cyc++;
    wa_cyc += wa;
    ws_cnt += ws;
    we_cnt += wend;
    dq_cnt += dq_oe;
    if (cyc == 3000) begin
      bad_count++;
      end_sim;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // sample 1 ns after the edge so registered outputs have landed
  task automatic at(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic clr;
    {wa_cyc, ws_cnt, we_cnt, dq_cnt} = '0;
  endtask

  task automatic power_up;
    @(posedge clk);
    sram_in <= 1'b0;
    clr();
    at(25);
    chk(rst_oe, 1);
    chk(sram_out, 1);
    @(posedge clk);
    host.access(3'h1, 3'h4, 1, 4);
    #1;
    chk(ws_cnt, 0);
    at(30);
    chk(rst_oe, 0);
    chk(sram_out, 0);
  endtask

  // overlap length, not the first fall, decides the write
  task automatic write_test(input logic [2:0] lo1, input logic [2:0] lo2);
    clr();
    @(posedge clk);
    host.access(lo1, lo2, 4, 8);
    at(1);
    chk(ws_cnt, 1);
    chk(we_cnt, 1);
    chk(wa_cyc, 8);
    chk(dq_cnt, 0);
  endtask

  task automatic read_test;
    clr();
    @(posedge clk);
    host.access(3'h1, 3'h2, 2, 6);
    at(1);
    chk(dq_cnt, 6);
    chk(ws_cnt, 0);
    @(posedge clk);
    sram_in <= 1'b1;
    at(4);
    chk(sram_out, 1);
    @(posedge clk);
    sram_in <= 1'b0;
    at(4);
    chk(sram_out, 0);
  endtask

  task automatic fail_test;
    @(posedge clk);
    irq_en <= 1'b1;
    sup_ok <= 1'b0;
    at(11);
    chk(irq_oe, 0);
    at(6);
    chk(irq_oe, 1);
    chk(irq_o, 0);
    at(13);
    chk(rst_oe, 0);
    chk(sram_out, 0);
    at(8);
    chk(rst_oe, 1);
    chk(sram_out, 1);
    chk(rst_o, 0);
    clr();
    @(posedge clk);
    host.access(3'h5, 3'h0, 1, 4);
    #1;
    chk(ws_cnt + dq_cnt, 0);
    @(posedge clk);
    irq_en <= 1'b0;
    sup_sw <= 1'b0;
    at(5);
    chk(irq_oe, 0);
    chk(bkp, 1);
    @(posedge clk);
    sup_sw <= 1'b1;
    sup_ok <= 1'b1;
    at(CSR - 15);
    chk(rst_oe, 1);
    chk(bkp, 0);
    at(25);
    chk(rst_oe, 0);
  endtask

  // single exit point for every path through the run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    power_up();
    write_test(3'h1, 3'h4);
    write_test(3'h6, 3'h1);
    read_test();
    fail_test();
    end_sim();
  end
endmodule
